// >>> core/async_serial_mode_and_baud.sv
// Purpose: Mode register and baud clock generator of an asynchronous serial interface
// Assumes: One 20 MHz clock; external serial clock pin is asynchronous to it
// Notes:   Notes on behaviour follow; shift registers and frame logic sit elsewhere
`timescale 1ns/1ps
`include "async_serial_defines.svh"
`default_nettype none

module async_serial_mode_and_baud
	import async_serial_pkg::*;
#(
	parameter int PRE_W = 10
) (
	input  wire logic               clk_i,
	input  wire logic               rstn_i,
	input  wire sfr_req_t           sfr_i,
	input  wire logic [3:0]         baud_prescale_select_i,
	input  wire logic               external_serial_clock_pin_i,
	output var  logic [7:0]         sfr_rdata_o,
	output var  async_serial_mode_t async_serial_mode_o,
	output var  serial_cfg_t        serial_cfg_o,
	output var  logic               clk_tick_o,
	output var  logic               bit_tick_o
);

	// ************************************************************************
	// Mode register
	// ************************************************************************
	async_serial_mode_t mode_q;
	logic [7:0]         mode_d;
	logic               hit;

	assign hit = (sfr_i.addr == `ASM_ADDR);

	always_comb begin
		mode_d = mode_q;
		if (hit && sfr_i.wr) begin
			mode_d = sfr_i.wdata;
		end else if (hit && sfr_i.bit_wr) begin
			mode_d[sfr_i.bit_sel] = sfr_i.bit_val;
		end
		// Reserved bits are held at zero whatever software writes
		mode_d = mode_d & `ASM_RESERVED_MASK;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_q <= `ASM_RESET;
		end else begin
			mode_q <= mode_d;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sfr_rdata_o <= 8'h00;
		end else begin
			sfr_rdata_o <= (hit && sfr_i.rd) ? mode_q : 8'h00;
		end
	end

	assign async_serial_mode_o = mode_q;

	// ************************************************************************
	// Decoded frame setup
	// ************************************************************************
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			serial_cfg_o <= '0;
		end else begin
			serial_cfg_o.tx_en           <= mode_q.tx_enable_bit;
			serial_cfg_o.rx_en           <= mode_q.rx_enable_bit;
			serial_cfg_o.parity          <= mode_q.parity_select;
			serial_cfg_o.tx_parity_gen   <= (mode_q.parity_select != PAR_NONE);
			serial_cfg_o.rx_parity_check <= mode_q.parity_select[1];
			serial_cfg_o.data_bits       <= mode_q.char_length_select ?
				`DATA_BITS_LONG : `DATA_BITS_SHORT;
			serial_cfg_o.stop_bits       <= mode_q.stop_length_select ?
				`STOP_BITS_TWO : `STOP_BITS_ONE;
		end
	end

	// ************************************************************************
	// External clock pin synchroniser
	// ************************************************************************
	logic [2:0] ext_sync_q;
	logic       ext_level_q;
	logic       ext_rise;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ext_sync_q  <= 3'h0;
			ext_level_q <= 1'b0;
		end else begin
			ext_sync_q <= {ext_sync_q[1:0], external_serial_clock_pin_i};
			// A change counts only once the second and third stage agree
			if (ext_sync_q[1] == ext_sync_q[2]) begin
				ext_level_q <= ext_sync_q[2];
			end
		end
	end

	assign ext_rise = (ext_sync_q[1] == ext_sync_q[2]) && ext_sync_q[2] && !ext_level_q;

	// ************************************************************************
	// Baud divider
	// ************************************************************************
	logic             use_ext;
	logic [3:0]       n_exp;
	logic [PRE_W-1:0] pre_limit;
	logic [PRE_W-1:0] pre_cnt_q;
	logic [2:0]       sub_cnt_q;
	logic             run;
	logic             pre_hit;

	// Top bit of the prescale field selects the pin; other codes give n = code + 1
	assign use_ext   = baud_prescale_select_i[`BAUD_SEL_EXT_BIT];
	assign n_exp     = {1'b0, baud_prescale_select_i[2:0]} + 4'h1;
	assign pre_limit = (PRE_W'(1) << (n_exp + 4'h1)) - PRE_W'(1);
	assign run       = mode_q.tx_enable_bit || mode_q.rx_enable_bit;
	assign pre_hit   = use_ext ? ext_rise : (pre_cnt_q >= pre_limit);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pre_cnt_q <= '0;
		end else if (!run || use_ext || pre_hit) begin
			pre_cnt_q <= '0;
		end else begin
			pre_cnt_q <= pre_cnt_q + PRE_W'(1);
		end
	end

	// Divide by eight gives the bit rate; stopping both directions parks the divider
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sub_cnt_q  <= 3'h0;
			clk_tick_o <= 1'b0;
			bit_tick_o <= 1'b0;
		end else if (!run) begin
			sub_cnt_q  <= 3'h0;
			clk_tick_o <= 1'b0;
			bit_tick_o <= 1'b0;
		end else begin
			clk_tick_o <= pre_hit;
			bit_tick_o <= pre_hit && (sub_cnt_q == `BAUD_OVERSAMPLE);
			if (pre_hit) begin
				sub_cnt_q <= sub_cnt_q + 3'h1;
			end
		end
	end

	// ************************************************************************
	// Checks
	// ************************************************************************
	logic             seen_q;
	logic [PRE_W:0]   gap_q;
	logic [3:0]       sel_hold_q;
	logic             stable_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			seen_q     <= 1'b0;
			gap_q      <= '0;
			sel_hold_q <= 4'h0;
			stable_q   <= 1'b0;
		end else begin
			seen_q     <= 1'b1;
			sel_hold_q <= baud_prescale_select_i;
			gap_q      <= clk_tick_o ? (PRE_W+1)'(1) : gap_q + (PRE_W+1)'(1);
			if (clk_tick_o && stable_q) begin
				stable_q <= 1'b1;
			end else if (clk_tick_o) begin
				stable_q <= 1'b1;
			end
			if (!run || use_ext || sel_hold_q != baud_prescale_select_i) begin
				stable_q <= 1'b0;
			end
		end
	end

	sequence s_byte_wr;
		hit && sfr_i.wr;
	endsequence

	sequence s_bit_wr;
		hit && !sfr_i.wr && sfr_i.bit_wr && sfr_i.bit_sel >= 3'd2;
	endsequence

	a_reset_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!seen_q |-> mode_q == `ASM_RESET) else $error("mode not clear after reset");

	a_byte_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_byte_wr |=> mode_q == ($past(sfr_i.wdata) & `ASM_RESERVED_MASK))
		else $error("byte write not stored");

	a_bit_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_bit_wr |=> mode_q[$past(sfr_i.bit_sel)] == $past(sfr_i.bit_val))
		else $error("bit write not stored");

	a_sys_period: assert property (@(posedge clk_i) disable iff (!rstn_i)
		clk_tick_o && stable_q && !use_ext |-> gap_q == (PRE_W+1)'(pre_limit) + 1'b1)
		else $error("system divider period wrong");

	a_ext_edge: assert property (@(posedge clk_i) disable iff (!rstn_i)
		run && use_ext && ext_rise ##1 (run && use_ext) |-> clk_tick_o)
		else $error("pin edge gave no tick");

	a_bit_rate: assert property (@(posedge clk_i) disable iff (!rstn_i)
		bit_tick_o |-> clk_tick_o && $past(sub_cnt_q) == `BAUD_OVERSAMPLE)
		else $error("bit tick not every eighth tick");

	a_stopped_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!mode_q.tx_enable_bit && !mode_q.rx_enable_bit |=> !clk_tick_o && !bit_tick_o)
		else $error("divider runs while stopped");

	a_field_map: assert property (@(posedge clk_i) disable iff (!rstn_i)
		seen_q |=> serial_cfg_o.parity == $past(mode_q.parity_select)
		&& serial_cfg_o.rx_parity_check == $past(mode_q.parity_select[1])
		&& serial_cfg_o.tx_en == $past(mode_q.tx_enable_bit)
		&& serial_cfg_o.rx_en == $past(mode_q.rx_enable_bit))
		else $error("parity or enable decode wrong");

	a_len_map: assert property (@(posedge clk_i) disable iff (!rstn_i)
		mode_q.char_length_select ##1 1'b1 |-> serial_cfg_o.data_bits == `DATA_BITS_LONG)
		else $error("eight bit length not decoded");

	a_stop_map: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!mode_q.stop_length_select |=> serial_cfg_o.stop_bits == `STOP_BITS_ONE)
		else $error("one stop bit not decoded");

endmodule // async_serial_mode_and_baud

`default_nettype wire

// >>> core/async_serial_defines.svh
// Purpose: Offsets, field positions, reset values and divider figures of the serial mode block
// Assumes: Byte-wide special function register space with 16-bit addresses
// Notes:   Definitions only
`ifndef ASYNC_SERIAL_DEFINES_SVH
`define ASYNC_SERIAL_DEFINES_SVH

// ****************************************************************************
// Register map
// ****************************************************************************
`define ASM_ADDR          16'hff70
`define ASM_RESET         8'h00
`define ASM_RESERVED_MASK 8'hfc

// ****************************************************************************
// Field positions
// ****************************************************************************
`define ASM_TX_EN_BIT     3'd7
`define ASM_RX_EN_BIT     3'd6
`define ASM_PAR_HI_BIT    3'd5
`define ASM_PAR_LO_BIT    3'd4
`define ASM_CHAR_LEN_BIT  3'd3
`define ASM_STOP_LEN_BIT  3'd2

// ****************************************************************************
// Baud divider and frame lengths
// ****************************************************************************
`define BAUD_OVERSAMPLE   3'd7
`define BAUD_SEL_EXT_BIT  2'd3
`define BAUD_N_MIN        4'd2
`define BAUD_N_MAX        4'd8
`define DATA_BITS_SHORT   4'h7
`define DATA_BITS_LONG    4'h8
`define STOP_BITS_ONE     2'h1
`define STOP_BITS_TWO     2'h2

`endif

// >>> core/async_serial_pkg.sv
// Purpose: Types shared by the serial mode block and its bench
// Assumes: Constants live in async_serial_defines.svh
// Notes:   Mode layout follows the register bit order, MSB first
package async_serial_pkg;

	typedef enum logic [1:0] {
		PAR_NONE = 2'b00,
		PAR_ZERO = 2'b01,
		PAR_ODD  = 2'b10,
		PAR_EVEN = 2'b11
	} parity_mode_t;

	typedef struct packed {
		logic         tx_enable_bit;
		logic         rx_enable_bit;
		parity_mode_t parity_select;
		logic         char_length_select;
		logic         stop_length_select;
		logic [1:0]   reserved;
	} async_serial_mode_t;

	typedef struct packed {
		logic         tx_en;
		logic         rx_en;
		parity_mode_t parity;
		logic         tx_parity_gen;
		logic         rx_parity_check;
		logic [3:0]   data_bits;
		logic [1:0]   stop_bits;
	} serial_cfg_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic [7:0]  wdata;
		logic        bit_wr;
		logic [2:0]  bit_sel;
		logic        bit_val;
		logic        rd;
	} sfr_req_t;

endpackage

// >>> verif/ext_clock_source.sv
// Purpose: Far-side clock source that drives the external serial clock pin
// Assumes: Each rise of start_i asks for one burst of PULSES clock periods
// Notes:   The pin rests low between bursts, like a clock that only runs for a frame
`timescale 1ns/1ps
`default_nettype none

module ext_clock_source #(
	parameter int PULSES = 10
) (
	input  wire logic start_i,
	output var  logic pin_o
);
	// ****************************************************************************
	// Burst generator
	// ****************************************************************************
	// The 500 ns period is kept unrelated in phase to the 50 ns system clock
	// One process owns the pin so it has a single driver
	initial begin
		pin_o = 1'b0;
		forever begin
			@(posedge start_i);
			repeat (PULSES) begin
				#213 pin_o = 1'b1;
				#287 pin_o = 1'b0;
			end
		end
	end
endmodule // ext_clock_source
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the serial mode register and baud clock
// Assumes: Register port strobes are one-cycle pulses, inputs driven at falling edges
// Notes:   Divider periods are measured in clock cycles between tick pulses
`timescale 1ns/1ps
`include "async_serial_defines.svh"
`default_nettype none

module tb_top;
	import async_serial_pkg::*;
	logic               clk_i       = 1'b0;
	logic               rstn_i      = 1'b0;
	sfr_req_t           sfr_i       = '0;
	logic [3:0]         presc       = 4'h1;
	logic               ext_go      = 1'b0;
	logic               ext_pin;
	logic [7:0]         rdata;
	logic [7:0]         d;
	async_serial_mode_t mode;
	serial_cfg_t        cfg;
	logic               clk_tick;
	logic               bit_tick;
	int                 num_errors  = 0;
	int                 checks_done = 0;
	int                 ticks       = 0;
	int                 bits        = 0;
	int                 g;
	int                 t0;
	int                 b0;

	async_serial_mode_and_baud #(.PRE_W(10)) DUT (
		.clk_i                       (clk_i),
		.rstn_i                      (rstn_i),
		.sfr_i                       (sfr_i),
		.baud_prescale_select_i      (presc),
		.external_serial_clock_pin_i (ext_pin),
		.sfr_rdata_o                 (rdata),
		.async_serial_mode_o         (mode),
		.serial_cfg_o                (cfg),
		.clk_tick_o                  (clk_tick),
		.bit_tick_o                  (bit_tick)
	);
	ext_clock_source #(.PULSES(10)) peer (.start_i(ext_go), .pin_o(ext_pin));

	// ****************************************************************************
	// Clock, tick counters and shared tasks
	// ****************************************************************************
	always #25 clk_i = ~clk_i;
	always @(negedge clk_i) begin
		ticks += int'(clk_tick === 1'b1);
		bits += int'(bit_tick === 1'b1);
	end

	task automatic results;
		if (num_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic chkn(input int got, input int exp);
		chk8(8'(got), 8'(exp));
		if (got > 255 || exp > 255)
			chk8(8'(got >> 8), 8'(exp >> 8));
	endtask

	task automatic wr_byte(input logic [15:0] a, input logic [7:0] v);
		@(negedge clk_i);
		sfr_i.addr = a;
		sfr_i.wdata = v;
		sfr_i.wr = 1'b1;
		@(negedge clk_i);
		sfr_i.wr = 1'b0;
	endtask

	task automatic wr_bit(input logic [2:0] s, input logic v);
		@(negedge clk_i);
		sfr_i.addr = `ASM_ADDR;
		sfr_i.bit_sel = s;
		sfr_i.bit_val = v;
		sfr_i.bit_wr = 1'b1;
		@(negedge clk_i);
		sfr_i.bit_wr = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(negedge clk_i);
		sfr_i.addr = a;
		sfr_i.rd = 1'b1;
		@(negedge clk_i);
		sfr_i.rd = 1'b0;
		v = rdata;
	endtask

	// Bounded so a stuck divider ends the run instead of hanging it
	task automatic tick_gap(input bit use_bit, output int n);
		int k;
		k = 0;
		while ((use_bit ? bit_tick : clk_tick) !== 1'b1 && k < 5000) begin
			@(negedge clk_i);
			k++;
		end
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while ((use_bit ? bit_tick : clk_tick) !== 1'b1 && n < 5000);
		if (k >= 5000 || n >= 5000) begin
			num_errors++;
			results();
		end
	endtask

	// ****************************************************************************
	// Main sequence
	// ****************************************************************************
	initial begin
		repeat (2) @(posedge clk_i);
		@(negedge clk_i) rstn_i = 1'b1;
		chk8(mode, `ASM_RESET);
		rd(`ASM_ADDR, d);
		chk8(d, 8'h00);
		wr_byte(`ASM_ADDR, 8'hfc);
		rd(`ASM_ADDR, d);
		chk8(d, 8'hfc);
		// Stop both directions first, only then touch the frame format
		wr_byte(`ASM_ADDR, 8'h3c);
		chk8(mode, 8'h3c);
		wr_byte(`ASM_ADDR, 8'h00);
		wr_bit(3'd2, 1'b1);
		wr_bit(3'd7, 1'b1);
		rd(`ASM_ADDR, d);
		chk8(d, 8'h84);
		wr_bit(3'd7, 1'b0);
		wr_byte(16'hff71, 8'hc0);
		chk8(mode, 8'h04);
		rd(16'hff71, d);
		chk8(d, 8'h00);
		// Enables stay clear while the frame format changes
		for (int i = 0; i < 16; i++) begin
			wr_byte(`ASM_ADDR, {2'b00, 4'(i), 2'b00});
			@(negedge clk_i);
			chk8({cfg.tx_en, cfg.rx_en, cfg.parity, cfg.tx_parity_gen, cfg.rx_parity_check, 2'b00},
				{2'b00, 2'(i >> 2), i >= 4, i >= 8, 2'b00});
			chk8({cfg.data_bits, 2'b00, cfg.stop_bits},
				{(i & 2) != 0 ? `DATA_BITS_LONG : `DATA_BITS_SHORT, 2'b00,
				(i & 1) != 0 ? `STOP_BITS_TWO : `STOP_BITS_ONE});
		end
		wr_byte(`ASM_ADDR, 8'h00);
		// Counters are owned by the sampling process; scenarios take snapshots
		t0 = ticks;
		repeat (600) @(negedge clk_i);
		chkn(ticks - t0, 0);
		// Codes 1 and 7 give the two ends of the exponent range, n = 2 and n = 8
		for (int c = 1; c < 8; c += 6) begin
			wr_byte(`ASM_ADDR, 8'h00);
			presc = 4'(c);
			wr_byte(`ASM_ADDR, c == 1 ? 8'h80 : 8'h40);
			tick_gap(1'b0, g);
			chkn(g, 2 ** (c + 2));
			tick_gap(1'b1, g);
			chkn(g, 2 ** (c + 5));
		end
		wr_byte(`ASM_ADDR, 8'h00);
		presc = 4'h8;
		wr_byte(`ASM_ADDR, 8'hc0);
		t0 = ticks;
		b0 = bits;
		@(negedge clk_i) ext_go = 1'b1;
		repeat (120) @(negedge clk_i);
		chkn(ticks - t0, 10);
		chkn(bits - b0, 1);
		// The pins go to three-wire use only with the register back at 00h
		wr_byte(`ASM_ADDR, 8'h00);
		rd(`ASM_ADDR, d);
		chk8(d, 8'h00);
		results();
	end
endmodule // tb_top
`default_nettype wire
